// File: asp_chk.sv
`timescale 1ns/100ps
// ****************************************
// port checker
// ****************************************
module asp_chk (
   // clock and reset
   input  wire logic        CLK_IN,
   input  wire logic        SRST_IN,
   // serial link
   input  wire logic        CS_N_IN,
   input  wire logic        DOUT_OUT,
   input  wire logic        DOUT_OE_N_OUT,
   // status and stream
   input  wire logic        POWER_ACTIVE_OUT,
   input  wire logic        OVERRUN_OUT,
   input  wire logic        RESULT_VALID_OUT,
   input  wire logic        RESULT_READY_IN,
   input  wire logic [11:0] RESULT_CODE_OUT,
   input  wire logic [1:0]  RESULT_CHAN_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (SRST_IN);
   // select level held past the sync stages
   sequence s_off; CS_N_IN [*4]; endsequence
   sequence s_on; !CS_N_IN [*4]; endsequence
   property p_oe_off; s_off |-> DOUT_OE_N_OUT; endproperty
   property p_oe_on; s_on |-> !DOUT_OE_N_OUT; endproperty
   property p_oe_delay; !DOUT_OE_N_OUT |-> !$past(CS_N_IN, 3); endproperty
   property p_dout_zero; CS_N_IN |-> !DOUT_OUT; endproperty
   property p_pwr_off; s_off |-> !POWER_ACTIVE_OUT; endproperty
   property p_pwr_on; $fell(CS_N_IN) |-> ##[2:5] POWER_ACTIVE_OUT; endproperty
   property p_hold;
      RESULT_VALID_OUT && !RESULT_READY_IN |=>
         RESULT_VALID_OUT && $stable(RESULT_CODE_OUT) && $stable(RESULT_CHAN_OUT);
   endproperty
   property p_sticky; OVERRUN_OUT |=> OVERRUN_OUT; endproperty
   a_oe_off: assert property (p_oe_off) else $error("output driven while deselected");
   a_oe_on: assert property (p_oe_on) else $error("output released while selected");
   a_oe_delay: assert property (p_oe_delay) else $error("output enabled too early");
   a_dout_zero: assert property (p_dout_zero) else $error("data high while deselected");
   a_pwr_off: assert property (p_pwr_off) else $error("powered while deselected");
   a_pwr_on: assert property (p_pwr_on) else $error("not powered after select");
   a_hold: assert property (p_hold) else $error("result changed while stalled");
   a_sticky: assert property (p_sticky) else $error("overrun flag dropped");
endmodule
bind asp_top asp_chk asp_chk_inst (.CLK_IN, .SRST_IN, .CS_N_IN, .DOUT_OUT, .DOUT_OE_N_OUT, .POWER_ACTIVE_OUT,
   .OVERRUN_OUT, .RESULT_VALID_OUT, .RESULT_READY_IN, .RESULT_CODE_OUT, .RESULT_CHAN_OUT);

// File: asp_core.sv
`timescale 1ns/100ps
// ****************************************
// result fifo with registered head
// ****************************************
module asp_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             srst_in,
   // fill side
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // drain side
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [WIDTH-1:0] nxt_mem [DEPTH];
   logic [AW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [AW:0]      cnt_ff, nxt_cnt;
   logic             ov_ff, nxt_ov;
   logic [WIDTH-1:0] od_ff, nxt_od;
   logic             push, pop;

   assign in_ready_out  = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid_out = ov_ff;
   assign out_data_out  = od_ff;

   // storage moves into the head register when it empties or drains
   always_comb begin
      push    = in_valid_in && in_ready_out;
      pop     = (cnt_ff != '0) && (!ov_ff || out_ready_in);
      nxt_mem = mem_ff;
      nxt_wr  = wr_ff;
      nxt_rd  = rd_ff;
      nxt_od  = od_ff;
      nxt_ov  = ov_ff && !out_ready_in;
      if (push) begin
         nxt_mem[wr_ff] = in_data_in;
         nxt_wr         = wr_ff + 1'b1;
      end
      if (pop) begin
         nxt_od = mem_ff[rd_ff];
         nxt_ov = 1'b1;
         nxt_rd = rd_ff + 1'b1;
      end
      nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
         ov_ff  <= 1'b0;
         od_ff  <= '0;
      end else begin
         wr_ff  <= nxt_wr;
         rd_ff  <= nxt_rd;
         cnt_ff <= nxt_cnt;
         ov_ff  <= nxt_ov;
         od_ff  <= nxt_od;
      end
      mem_ff <= nxt_mem;
   end
endmodule

// ****************************************
// serial converter framing and power control
// ****************************************
module asp_top (
   // system clock and reset
   input  wire logic        CLK_IN,
   input  wire logic        SRST_IN,
   // serial link
   input  wire logic        SCLK_IN,
   input  wire logic        CS_N_IN,
   input  wire logic        DIN_IN,
   output logic             DOUT_OUT,
   output logic             DOUT_OE_N_OUT,
   // input levels, fraction of supply
   input  wire logic [15:0] AIN1_IN,
   input  wire logic [15:0] AIN2_IN,
   input  wire logic [15:0] AIN3_IN,
   input  wire logic [15:0] AIN4_IN,
   // status
   output logic             POWER_ACTIVE_OUT,
   output logic             OVERRUN_OUT,
   output logic             FIFO_READY_OUT,
   // result stream
   output logic             RESULT_VALID_OUT,
   input  wire logic        RESULT_READY_IN,
   output logic [11:0]      RESULT_CODE_OUT,
   output logic [1:0]       RESULT_CHAN_OUT
);
   // ideal quantiser with half-step first transition
   function automatic logic [11:0] quantize(input logic [15:0] lvl);
      logic [16:0] sum;
      sum = {1'b0, lvl} + asp_pkg::HALF_STEP;                       // RULE2
      if (sum[16])
         quantize = asp_pkg::CODE_MAX;
      else
         quantize = sum[15:asp_pkg::STEP_SHIFT];                   // RULE1
   endfunction

   logic [15:0] ain [asp_pkg::NUM_CHAN];
   assign ain[0] = AIN1_IN;
   assign ain[1] = AIN2_IN;
   assign ain[2] = AIN3_IN;
   assign ain[3] = AIN4_IN;

   // ****************************************
   // link domain: rising edges
   // ****************************************
   logic [3:0]  rise_ff, nxt_rise;
   logic [1:0]  chan_ff, nxt_chan;
   logic [15:0] ain_meta_ff [asp_pkg::NUM_CHAN];
   logic [15:0] ain_sync_ff [asp_pkg::NUM_CHAN];

   // rising edge count inside the conversion, cleared by chip select
   always_comb begin
      nxt_rise = rise_ff + 4'h1;                                    // RULE5 RULE6
   end

   always_ff @(posedge SCLK_IN or posedge CS_N_IN) begin
      if (CS_N_IN)
         rise_ff <= 4'h0;
      else
         rise_ff <= nxt_rise;
   end

   // channel select bits taken on the fourth and fifth rising edges
   always_comb begin
      nxt_chan = chan_ff;
      if (rise_ff == asp_pkg::SEL_HI_AT)
         nxt_chan[1] = DIN_IN;                                      // RULE9
      if (rise_ff == asp_pkg::SEL_LO_AT)
         nxt_chan[0] = DIN_IN;                                      // RULE9
   end

   always_ff @(posedge SCLK_IN or posedge SRST_IN) begin
      if (SRST_IN)
         chan_ff <= asp_pkg::CHAN_DEFAULT;                          // RULE11
      else
         chan_ff <= nxt_chan;
   end

   // input levels settle through two stages during tracking
   generate
      for (genvar i = 0; i < asp_pkg::NUM_CHAN; i++) begin : g_track
         always_ff @(posedge SCLK_IN) begin
            ain_meta_ff[i] <= ain[i];
            ain_sync_ff[i] <= ain_meta_ff[i];                      // RULE8
         end
      end
   endgenerate

   // ****************************************
   // link domain: falling edges
   // ****************************************
   logic        dout_ff, nxt_dout;
   logic        pd_ff, nxt_pd;
   logic [11:0] hold_code_ff, nxt_hold_code;
   logic [1:0]  hold_chan_ff, nxt_hold_chan;
   logic        tgl_ff, nxt_tgl;

   // hold the sample at the end of tracking and flag it across
   always_comb begin
      nxt_hold_code = hold_code_ff;
      nxt_hold_chan = hold_chan_ff;
      nxt_tgl       = tgl_ff;
      if (!CS_N_IN && rise_ff == asp_pkg::HOLD_AT) begin
         nxt_hold_code = quantize(ain_sync_ff[chan_ff]);            // RULE8 RULE1
         nxt_hold_chan = chan_ff;
         nxt_tgl       = !tgl_ff;
      end
   end

   always_ff @(negedge SCLK_IN or posedge SRST_IN) begin
      if (SRST_IN) begin
         hold_code_ff <= 12'h000;
         hold_chan_ff <= 2'h0;
         tgl_ff       <= 1'b0;
      end else begin
         hold_code_ff <= nxt_hold_code;
         hold_chan_ff <= nxt_hold_chan;
         tgl_ff       <= nxt_tgl;
      end
   end

   // serial data and automatic power-down, both driven on falling edges
   always_comb begin
      nxt_dout = 1'b0;                                              // RULE12
      if (rise_ff == asp_pkg::HOLD_AT)
         nxt_dout = 1'b0;                                           // RULE12
      else if (rise_ff >= asp_pkg::MSB_AT)
         nxt_dout = hold_code_ff[asp_pkg::BIT_BASE - rise_ff];      // RULE8
      nxt_pd = (rise_ff == asp_pkg::LAST_AT);                       // RULE4
   end

   always_ff @(negedge SCLK_IN or posedge CS_N_IN) begin
      if (CS_N_IN) begin
         dout_ff <= 1'b0;
         pd_ff   <= 1'b0;
      end else begin
         dout_ff <= nxt_dout;
         pd_ff   <= nxt_pd;
      end
   end

   assign DOUT_OUT = dout_ff;

   // ****************************************
   // system domain: crossings and status
   // ****************************************
   logic       cs_meta_ff, cs_sync_ff;
   logic       pd_meta_ff, pd_sync_ff;
   logic       tg_meta_ff, tg_sync_ff, tg_prev_ff;
   logic       oe_n_ff, nxt_oe_n;
   logic       pwr_ff, nxt_pwr;
   logic       push_ff, nxt_push;
   logic [13:0] push_d_ff, nxt_push_d;
   logic       ovr_ff, nxt_ovr;
   logic       frdy_ff, nxt_frdy;
   logic       fifo_in_ready;

   // output enable and power follow the frame and idle gap
   always_comb begin
      nxt_oe_n   = cs_sync_ff;                                      // RULE10
      nxt_pwr    = !cs_sync_ff && !pd_sync_ff;                      // RULE3 RULE4
      nxt_push   = (tg_sync_ff != tg_prev_ff);
      nxt_push_d = push_d_ff;                                       // word only taken once the toggle has settled
      if (nxt_push)
         nxt_push_d = {hold_chan_ff, hold_code_ff};
      nxt_ovr    = ovr_ff || (push_ff && !fifo_in_ready);
      nxt_frdy   = fifo_in_ready;
   end

   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         cs_meta_ff <= 1'b1;
         cs_sync_ff <= 1'b1;
         pd_meta_ff <= 1'b0;
         pd_sync_ff <= 1'b0;
         tg_meta_ff <= 1'b0;
         tg_sync_ff <= 1'b0;
         tg_prev_ff <= 1'b0;
         oe_n_ff    <= 1'b1;
         pwr_ff     <= 1'b0;
         push_ff    <= 1'b0;
         push_d_ff  <= 14'h0000;
         ovr_ff     <= 1'b0;
         frdy_ff    <= 1'b0;
      end else begin
         cs_meta_ff <= CS_N_IN;
         cs_sync_ff <= cs_meta_ff;
         pd_meta_ff <= pd_ff;
         pd_sync_ff <= pd_meta_ff;
         tg_meta_ff <= tgl_ff;
         tg_sync_ff <= tg_meta_ff;
         tg_prev_ff <= tg_sync_ff;
         oe_n_ff    <= nxt_oe_n;
         pwr_ff     <= nxt_pwr;
         push_ff    <= nxt_push;
         push_d_ff  <= nxt_push_d;
         ovr_ff     <= nxt_ovr;
         frdy_ff    <= nxt_frdy;
      end
   end

   assign DOUT_OE_N_OUT    = oe_n_ff;
   assign POWER_ACTIVE_OUT = pwr_ff;
   assign OVERRUN_OUT      = ovr_ff;
   assign FIFO_READY_OUT   = frdy_ff;

   // ****************************************
   // result buffer
   // ****************************************
   logic [13:0] fifo_out;

   asp_fifo #(
      .WIDTH (asp_pkg::FIFO_WIDTH),
      .DEPTH (asp_pkg::FIFO_DEPTH)
   ) asp_fifo_inst (
      .clk_in        (CLK_IN),
      .srst_in       (SRST_IN),
      .in_valid_in   (push_ff),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (push_d_ff),
      .out_valid_out (RESULT_VALID_OUT),
      .out_ready_in  (RESULT_READY_IN),
      .out_data_out  (fifo_out)
   );

   assign RESULT_CODE_OUT = fifo_out[11:0];
   assign RESULT_CHAN_OUT = fifo_out[13:12];
endmodule

// File: asp_fifo_unused_placeholder.sv
`timescale 1ns/100ps
// ****************************************
// intentionally empty compile unit
// ****************************************

// File: asp_host.sv
`timescale 1ns/100ps
// ****************************************
// host serial port model
// ****************************************
module asp_host (
   // serial link
   output logic      sclk_out,
   output logic      cs_n_out,
   output logic      din_out,
   input  wire logic dout_in,
   input  wire logic dout_oe_n_in
);
   logic [15:0] words[$];
   logic [15:0] acc;
   int          cnt;
   // fixed link clock; power is traded by fewer conversions, not a slower clock
   localparam int HALF_NS = 16;
   // idle link, clock parked high
   initial begin
      sclk_out = 1'b1;
      cs_n_out = 1'b1;
      din_out  = 1'b0;
      cnt      = 0;
   end
   // select, then wait lead time before clocking
   task automatic open_frame(input int lead);
      cs_n_out = 1'b0;
      cnt      = 0;
      #(lead);
   endtask
   // n cycles of 32 ns, control byte selects ch
   task automatic clocks(input int n, input logic [1:0] ch);
      logic [7:0] ctrl;
      ctrl = {3'h0, ch, 3'h0};
      for (int i = 0; i < n; i++) begin
         sclk_out = 1'b0;
         din_out  = (cnt % 16 < 8) ? ctrl[7 - cnt % 16] : ~din_out;
         #(HALF_NS);
         sclk_out = 1'b1;
         acc      = {acc[14:0], dout_oe_n_in ? ~dout_in : dout_in};
         if (cnt % 16 == 15) words.push_back(acc);
         cnt++;
         #(HALF_NS);
      end
   endtask
   // deselect after a whole number of conversions
   task automatic close_frame();
      cs_n_out = 1'b1;
      din_out  = ~din_out;
   endtask
endmodule

// File: asp_pkg.sv
// Behaviour
// RULE1: result is a 12-bit straight-binary code, one step is supply divided by 4096
// RULE2: first code change at half a step, later changes one full step apart
// RULE3: powered while chip select low, powered down while chip select high
// RULE4: auto power-down from sixteenth falling edge to next conversion's first falling edge
// RULE5: each conversion takes exactly 16 serial clocks, back to back allowed
// RULE6: conversions keep starting every 16 clocks while chip select stays low
// RULE7: host keeps serial clock at or below 3.2 MHz; asp_host runs 32 ns periods, 31.25 MHz
// RULE8: track three clocks, convert thirteen, result out MSB first from fifth clock
// RULE9: control byte on first eight rising edges, bits 4 and 3 pick next input
// RULE10: frames hold whole multiples of 16 edges; output released while deselected
// RULE11: first conversion after power-up samples input one, no dummy cycle
// RULE12: bit periods before and after the 12 result bits read as zero
package asp_pkg;
   // ****************************************
   // result format
   // ****************************************
   localparam int          RES_BITS     = 12;
   localparam logic [11:0] CODE_MAX     = 12'hfff;
   localparam int          AIN_BITS     = 16;            // input level in units of supply/65536
   localparam logic [16:0] HALF_STEP    = 17'h00008;     // half a code step in input units
   localparam int          STEP_SHIFT   = 4;             // 65536 / 4096 input units per step
   localparam int          NUM_CHAN     = 4;
   localparam logic [1:0]  CHAN_DEFAULT = 2'h0;

   // ****************************************
   // conversion framing, counted in rising edges so far
   // ****************************************
   localparam int          CONV_CYCLES  = 16;
   localparam logic [3:0]  HOLD_AT      = 4'h3;          // fourth falling edge ends tracking
   localparam logic [3:0]  MSB_AT       = 4'h4;          // fifth clock carries the result msb
   localparam logic [3:0]  LAST_AT      = 4'hf;          // sixteenth falling edge
   localparam logic [3:0]  SEL_HI_AT    = 4'h3;          // fourth rising edge: control bit 4
   localparam logic [3:0]  SEL_LO_AT    = 4'h4;          // fifth rising edge: control bit 3
   localparam logic [3:0]  BIT_BASE     = 4'hf;          // result bit index = BIT_BASE - count

   // ****************************************
   // timing and buffering
   // ****************************************
   localparam int          CLK_PERIOD_NS   = 25;
   localparam int          SCLK_MAX_KHZ    = 3200;
   localparam int          FIFO_DEPTH      = 16;
   localparam int          FIFO_WIDTH      = 14;         // channel and code
endpackage

// File: tb_adc_serial_power_framing.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
   $display("FAIL %s exp %h got %h", nm, e, g); end end
module tb_adc_serial_power_framing;
   logic        clk, srst, sclk, cs_n, din, dout, oe_n, pwr, ovr, frdy, rvalid, rready;
   logic [11:0] rcode;
   logic [1:0]  rchan;
   logic [15:0] ain [4];
   int          n_errors = 0;
   int          compares = 0;
   // device and host
   asp_top asp_top_inst (.CLK_IN(clk), .SRST_IN(srst), .SCLK_IN(sclk), .CS_N_IN(cs_n), .DIN_IN(din),
      .DOUT_OUT(dout), .DOUT_OE_N_OUT(oe_n), .AIN1_IN(ain[0]), .AIN2_IN(ain[1]), .AIN3_IN(ain[2]),
      .AIN4_IN(ain[3]), .POWER_ACTIVE_OUT(pwr), .OVERRUN_OUT(ovr), .FIFO_READY_OUT(frdy),
      .RESULT_VALID_OUT(rvalid), .RESULT_READY_IN(rready), .RESULT_CODE_OUT(rcode), .RESULT_CHAN_OUT(rchan));
   asp_host asp_host_inst (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .dout_in(dout), .dout_oe_n_in(oe_n));
   // system clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // verdict and end of run
   task automatic summarize();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ideal code, half step first transition
   function automatic logic [11:0] code_of(input logic [15:0] a);
      logic [16:0] s;
      s = {1'b0, a} + 17'h00008;
      return s[16] ? 12'hfff : s[15:4];
   endfunction
   task automatic settle();
      #200;
      @(posedge clk);
      #1;
   endtask
   // wait for head, check it, accept it
   task automatic pop(input logic [1:0] ch);
      int k;
      k = 0;
      @(posedge clk);
      #1;
      while (rvalid !== 1'b1) begin
         @(posedge clk);
         #1;
         if (++k > 2000) begin
            n_errors++;
            summarize();
         end
      end
      `CHK("chan", ch, rchan)
      `CHK("code", code_of(ain[ch]), rcode)
      rready = 1'b1;
      @(posedge clk);
      #1 rready = 1'b0;
   endtask
   // serial word and stream entry of one conversion
   task automatic res(input logic [1:0] ch);
      logic [15:0] w;
      w = asp_host_inst.words.pop_front();
      `CHK("word", {4'h0, code_of(ain[ch])}, w)
      pop(ch);
   endtask
   task automatic t_first();
      asp_host_inst.open_frame(100);
      asp_host_inst.clocks(16, 2'h1);
      asp_host_inst.close_frame();
      res(2'h0);
   endtask
   task automatic t_chain();
      asp_host_inst.open_frame(100);
      asp_host_inst.clocks(16, 2'h2);
      asp_host_inst.clocks(16, 2'h3);
      asp_host_inst.clocks(16, 2'h0);
      asp_host_inst.close_frame();
      for (int c = 1; c < 4; c++) res(c[1:0]);
   endtask
   task automatic t_power();
      asp_host_inst.open_frame(100);
      asp_host_inst.clocks(8, 2'h0);
      settle();
      `CHK("active", 1'b1, pwr)
      asp_host_inst.clocks(8, 2'h0);
      settle();
      `CHK("active", 1'b0, pwr)
      `CHK("oe_n", 1'b0, oe_n)
      asp_host_inst.clocks(1, 2'h0);
      settle();
      `CHK("active", 1'b1, pwr)
      asp_host_inst.clocks(15, 2'h0);
      asp_host_inst.close_frame();
      settle();
      `CHK("active", 1'b0, pwr)
      `CHK("oe_n", 1'b1, oe_n)
      res(2'h0);
      res(2'h0);
   endtask
   task automatic t_overrun();
      asp_host_inst.open_frame(100);
      asp_host_inst.clocks(288, 2'h1);
      asp_host_inst.close_frame();
      settle();
      `CHK("overrun", 1'b1, ovr)
      `CHK("room", 1'b0, frdy)
      asp_host_inst.words.delete();
      pop(2'h0);
      for (int i = 0; i < 16; i++) pop(2'h1);
      settle();
      `CHK("valid", 1'b0, rvalid)
   endtask
   // reset, then scenarios
   initial begin
      srst   = 1'b1;
      rready = 1'b0;
      ain    = '{16'h0008, 16'h0017, 16'h0018, 16'hffff};
      repeat (2) @(posedge clk);
      #1 srst = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      t_first();
      t_chain();
      t_power();
      t_overrun();
      summarize();
   end
endmodule
